// file: dsii_pkg.sv
// Constants, field layouts and carrier types for the drive status input image.
package dsii_pkg;

   // ************************************************************
   // Status word bit positions.
   // ************************************************************
   localparam int ST_SEQ_BUSY = 0;
   localparam int ST_MOTION = 1;
   localparam int ST_IN_POS = 2;
   localparam int ST_START_ECHO = 3;
   localparam int ST_HOME_DONE = 4;
   localparam int ST_READY = 5;
   localparam int ST_DIRECT_RDY = 6;
   localparam int ST_ALARM = 7;
   localparam int ST_TRIG_ECHO = 8;
   localparam int ST_TRIG_MODE_ECHO = 9;
   localparam int ST_SET_ERROR = 10;
   localparam int ST_EXEC_ERROR = 11;
   localparam int ST_BUF_BUSY = 12;
   localparam int ST_STOP_ECHO = 13;
   localparam int ST_TORQUE_OFF = 14;
   localparam int ST_TORQUE_LIMIT = 15;

   // ************************************************************
   // Image byte indices and register map.
   // ************************************************************
   localparam logic [4:0] BYTE_FIRST = 5'h04;
   localparam logic [4:0] BYTE_LAST = 5'h15;
   localparam logic [5:0] REG_CTRL = 6'h00;
   localparam logic [5:0] REG_WRAP_RANGE = 6'h01;
   localparam logic [5:0] REG_LIVE = 6'h02;
   localparam logic [5:0] REG_FRAMES = 6'h03;
   localparam logic [5:0] REG_IMG_FIRST = 6'h04;
   localparam logic [5:0] REG_IMG_LAST = 6'h08;
   localparam int CTRL_WRAP_EN = 0;
   localparam int CTRL_AUTO_EXCH = 1;
   localparam logic [31:0] WRAP_RANGE_RESET = 32'h0000_1000;

   // Direct-operation setting checks, one bit per setting.
   localparam int NUM_SETTINGS = 7;

   // Snapshot of the image fields, bytes 4 to 21.
   typedef struct packed {
      logic [15:0] status;
      logic [15:0] alarm_code;
      logic [31:0] fb_pos;
      logic [31:0] fb_speed;
      logic [31:0] cmd_pos;
      logic [15:0] torque;
   } dsii_image_t;

   // Flag sources from motion, safety and direct-operation units.
   typedef struct packed {
      logic seq_busy;
      logic motion;
      logic in_pos;
      logic home_complete;
      logic preset_done;
      logic home_start;
      logic ready;
      logic direct_ready;
      logic alarm;
      logic direct_fail;
      logic direct_ok;
      logic buf_writing;
      logic motor_excited;
      logic torque_limit;
   } dsii_flags_t;

   // Host command levels that are echoed back.
   typedef struct packed {
      logic start;
      logic trigger;
      logic trigger_mode;
      logic stop;
   } dsii_cmds_t;

   typedef enum logic [1:0] {
      SER_IDLE = 2'b00,
      SER_SEND = 2'b01,
      SER_DONE = 2'b10
   } dsii_ser_state_t;

endpackage

// file: dsii_input_image.sv
// Drive status input image framer with classic Wishbone register access.
module dsii_input_image (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Classic Wishbone slave.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // Flag sources and host command levels, same clock.
   input wire dsii_pkg::dsii_flags_t flags_i,
   input wire dsii_pkg::dsii_cmds_t cmds_i,
   input wire logic [dsii_pkg::NUM_SETTINGS-1:0] setting_bad_i,
   // Hardware torque-off pins, asynchronous, low means torque off demanded.
   input wire logic hw_torque_off_a_i,
   input wire logic hw_torque_off_b_i,
   // Monitor values.
   input wire logic [15:0] alarm_code_i,
   input wire logic [31:0] fb_pos_i,
   input wire logic [31:0] fb_speed_i,
   input wire logic [31:0] cmd_pos_i,
   input wire logic [15:0] torque_i,
   // Exchange request and image output.
   input wire logic exch_req_i,
   output dsii_pkg::dsii_image_t image_o,
   output logic [7:0] byte_o,
   output logic [4:0] byte_idx_o,
   output logic byte_valid_o,
   output logic frame_done_o
);
   import dsii_pkg::*;

   // ************************************************************
   // Pin synchronisers.
   // ************************************************************
   logic [2:0] hwa_sync;
   logic [2:0] hwb_sync;
   logic hwa_level;
   logic hwb_level;

   // Three stages; a pin change counts once stages two and three agree.
   // Stages reset to the idle high level, so no false drop follows reset.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hwa_sync <= 3'h7;
         hwb_sync <= 3'h7;
      end else begin
         hwa_sync <= {hwa_sync[1:0], hw_torque_off_a_i};
         hwb_sync <= {hwb_sync[1:0], hw_torque_off_b_i};
      end
   end

   // Filtered levels; they hold while stages two and three disagree.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         hwa_level <= 1'b1;
         hwb_level <= 1'b1;
      end else begin
         if (hwa_sync[1] == hwa_sync[2]) begin
            hwa_level <= hwa_sync[2];
         end
         if (hwb_sync[1] == hwb_sync[2]) begin
            hwb_level <= hwb_sync[2];
         end
      end
   end

   // ************************************************************
   // Control registers.
   // ************************************************************
   logic wrap_en;
   logic auto_exch;
   logic [31:0] wrap_range;
   logic [15:0] frame_count;
   logic bus_req;
   logic wr_hit;
   logic [5:0] reg_idx;

   // A request is answered exactly once, one cycle after it appears.
   assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr_hit = bus_req & wb_we_i;
   assign reg_idx = wb_adr_i[7:2];

   // Control register; byte lane zero holds the bits.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wrap_en <= 1'b0;
         auto_exch <= 1'b0;
      end else if (wr_hit && reg_idx == REG_CTRL && wb_sel_i[0]) begin
         wrap_en <= wb_dat_i[CTRL_WRAP_EN];
         auto_exch <= wb_dat_i[CTRL_AUTO_EXCH];
      end
   end

   // Wrap range, written per byte lane; zero disables wrapping.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wrap_range <= WRAP_RANGE_RESET;
      end else if (wr_hit && reg_idx == REG_WRAP_RANGE) begin
         for (int i = 0; i < 4; i++) begin
            if (wb_sel_i[i]) begin
               wrap_range[i*8 +: 8] <= wb_dat_i[i*8 +: 8];
            end
         end
      end
   end

   // ************************************************************
   // Sticky status flags.
   // ************************************************************
   logic home_done;
   logic exec_error;
   logic torque_off;
   logic hw_off_any;

   // Either channel low means torque off is demanded.
   assign hw_off_any = ~hwa_level | ~hwb_level;

   // Home done latches until a new homing run starts; a completion in
   // the same cycle as a start wins so the event is never lost.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         home_done <= 1'b0;
      end else if (flags_i.home_complete || flags_i.preset_done) begin
         home_done <= 1'b1;
      end else if (flags_i.home_start) begin
         home_done <= 1'b0;
      end
   end

   // Execute error stays until a direct operation succeeds.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         exec_error <= 1'b0;
      end else if (flags_i.direct_fail) begin
         exec_error <= 1'b1;
      end else if (flags_i.direct_ok) begin
         exec_error <= 1'b0;
      end
   end

   // Torque-off monitor holds from the drop of either channel until the
   // motor is excited again with both channels restored.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         torque_off <= 1'b0;
      end else if (hw_off_any) begin
         torque_off <= 1'b1;
      end else if (flags_i.motor_excited) begin
         torque_off <= 1'b0;
      end
   end

   // ************************************************************
   // Live status word.
   // ************************************************************
   logic [15:0] live_status;

   // Fixed bit positions; nothing in the register map can remap them.
   always_comb begin
      live_status = 16'h0000;
      live_status[ST_SEQ_BUSY] = flags_i.seq_busy;
      live_status[ST_MOTION] = flags_i.motion;
      live_status[ST_IN_POS] = flags_i.in_pos;
      live_status[ST_START_ECHO] = cmds_i.start;
      live_status[ST_HOME_DONE] = home_done;
      live_status[ST_READY] = flags_i.ready & ~flags_i.alarm;
      live_status[ST_DIRECT_RDY] = flags_i.direct_ready & ~flags_i.alarm;
      live_status[ST_ALARM] = flags_i.alarm;
      live_status[ST_TRIG_ECHO] = cmds_i.trigger;
      live_status[ST_TRIG_MODE_ECHO] = cmds_i.trigger_mode;
      live_status[ST_SET_ERROR] = |setting_bad_i;
      live_status[ST_EXEC_ERROR] = exec_error;
      live_status[ST_BUF_BUSY] = flags_i.buf_writing;
      live_status[ST_STOP_ECHO] = cmds_i.stop;
      live_status[ST_TORQUE_OFF] = torque_off;
      live_status[ST_TORQUE_LIMIT] = flags_i.torque_limit;
   end

   // ************************************************************
   // Wrap coordinates.
   // ************************************************************
   logic [31:0] fb_pos_view;
   logic [31:0] cmd_pos_view;

   // Signed modulo folded into 0 .. range-1. Wide combinational divide:
   // it costs area but keeps the snapshot to a single cycle.
   function automatic logic [31:0] wrap_pos(input logic [31:0] pos,
                                           input logic [31:0] range);
      logic signed [32:0] rem;
      rem = $signed({pos[31], pos}) % $signed({1'b0, range});
      if (rem < 0) begin
         rem = rem + $signed({1'b0, range});
      end
      return rem[31:0];
   endfunction

   // Range zero or wrap off passes the absolute counts.
   always_comb begin
      if (wrap_en && wrap_range != 32'h0000_0000) begin
         fb_pos_view = wrap_pos(fb_pos_i, wrap_range);
         cmd_pos_view = wrap_pos(cmd_pos_i, wrap_range);
      end else begin
         fb_pos_view = fb_pos_i;
         cmd_pos_view = cmd_pos_i;
      end
   end

   // ************************************************************
   // Snapshot capture.
   // ************************************************************
   dsii_ser_state_t ser_state;
   dsii_ser_state_t next_ser_state;
   logic take_snap;
   logic [4:0] ser_idx;

   // A request while a frame is still going out is dropped, not held;
   // auto mode re-arms right after every completed frame.
   assign take_snap = (ser_state == SER_IDLE) && (exch_req_i || auto_exch);

   // Every field is captured on the same edge.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         image_o <= '0;
      end else if (take_snap) begin
         image_o.status <= live_status;
         image_o.alarm_code <= alarm_code_i;
         image_o.fb_pos <= fb_pos_view;
         image_o.fb_speed <= fb_speed_i;
         image_o.cmd_pos <= cmd_pos_view;
         image_o.torque <= torque_i;
      end
   end

   // ************************************************************
   // Byte serialiser.
   // ************************************************************

   // Big-endian mapping of an image byte index to its content.
   function automatic logic [7:0] image_byte(input dsii_image_t img,
                                             input logic [4:0] idx);
      logic [7:0] b;
      b = 8'h00;
      case (idx)
         5'h04: b = img.status[15:8];
         5'h05: b = img.status[7:0];
         5'h06: b = img.alarm_code[15:8];
         5'h07: b = img.alarm_code[7:0];
         5'h08: b = img.fb_pos[31:24];
         5'h09: b = img.fb_pos[23:16];
         5'h0a: b = img.fb_pos[15:8];
         5'h0b: b = img.fb_pos[7:0];
         5'h0c: b = img.fb_speed[31:24];
         5'h0d: b = img.fb_speed[23:16];
         5'h0e: b = img.fb_speed[15:8];
         5'h0f: b = img.fb_speed[7:0];
         5'h10: b = img.cmd_pos[31:24];
         5'h11: b = img.cmd_pos[23:16];
         5'h12: b = img.cmd_pos[15:8];
         5'h13: b = img.cmd_pos[7:0];
         5'h14: b = img.torque[15:8];
         5'h15: b = img.torque[7:0];
         default: b = 8'h00;
      endcase
      return b;
   endfunction

   // Idle, send bytes 4..21 one per cycle, then one done cycle.
   always_comb begin
      next_ser_state = ser_state;
      case (ser_state)
         SER_IDLE: begin
            if (take_snap) begin
               next_ser_state = SER_SEND;
            end
         end
         SER_SEND: begin
            if (ser_idx == BYTE_LAST) begin
               next_ser_state = SER_DONE;
            end
         end
         SER_DONE: next_ser_state = SER_IDLE;
         default: next_ser_state = SER_IDLE;
      endcase
   end

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ser_state <= SER_IDLE;
      end else begin
         ser_state <= next_ser_state;
      end
   end

   // Byte pointer walks the whole image each frame.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         ser_idx <= BYTE_FIRST;
      end else if (ser_state != SER_SEND) begin
         ser_idx <= BYTE_FIRST;
      end else begin
         ser_idx <= ser_idx + 5'h01;
      end
   end

   // Byte outputs registered so they come straight from flops.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         byte_o <= 8'h00;
         byte_idx_o <= BYTE_FIRST;
         byte_valid_o <= 1'b0;
      end else begin
         byte_valid_o <= (ser_state == SER_SEND);
         byte_idx_o <= ser_idx;
         byte_o <= image_byte(image_o, ser_idx);
      end
   end

   // Done marks the cycle after the last byte; frames are counted.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frame_done_o <= 1'b0;
         frame_count <= 16'h0000;
      end else begin
         frame_done_o <= (ser_state == SER_DONE);
         if (ser_state == SER_DONE) begin
            frame_count <= frame_count + 16'h0001;
         end
      end
   end

   // ************************************************************
   // Wishbone answer.
   // ************************************************************
   logic [31:0] next_rd;
   logic [5:0] img_word;

   assign img_word = reg_idx - REG_IMG_FIRST;

   // Image words follow byte order 4..21; the last word is padded low.
   always_comb begin
      next_rd = 32'h0000_0000;
      if (reg_idx == REG_CTRL) begin
         next_rd[CTRL_WRAP_EN] = wrap_en;
         next_rd[CTRL_AUTO_EXCH] = auto_exch;
      end else if (reg_idx == REG_WRAP_RANGE) begin
         next_rd = wrap_range;
      end else if (reg_idx == REG_LIVE) begin
         next_rd = {live_status, alarm_code_i};
      end else if (reg_idx == REG_FRAMES) begin
         next_rd = {16'h0000, frame_count};
      end else if (reg_idx >= REG_IMG_FIRST && reg_idx <= REG_IMG_LAST) begin
         for (int i = 0; i < 4; i++) begin
            next_rd[31-i*8 -: 8] = image_byte(image_o,
               5'(BYTE_FIRST + 5'(img_word[2:0]) * 5'h04 + 5'(i)));
         end
      end
   end

   // Ack one cycle after the strobe, dropped the cycle after.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= bus_req;
         if (bus_req && !wb_we_i) begin
            wb_dat_o <= next_rd;
         end
      end
   end

endmodule

// file: dsii_host_model.sv
// Host controller model that requests exchanges and rebuilds the image.
module dsii_host_model (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Exchange request from the bench.
   input wire logic go_i,
   // Byte stream from the drive.
   input wire logic [7:0] byte_i,
   input wire logic [4:0] byte_idx_i,
   input wire logic byte_valid_i,
   input wire logic frame_done_i,
   // Request and rebuilt image.
   output logic exch_req_o,
   output dsii_pkg::dsii_image_t rx_o,
   output logic [15:0] frames_o
);
   import dsii_pkg::*;

   // One request cycle for each bench pulse.
   always_ff @(posedge clk_i) begin
      exch_req_o <= go_i && !rst_i;
   end

   // The image is preset to ones at each request, so a byte that never
   // arrives shows up as a mismatch instead of a stale match.
   always_ff @(posedge clk_i) begin
      if (rst_i || exch_req_o) begin
         rx_o <= '1;
      end else if (byte_valid_i) begin
         rx_o[143 - 8 * (int'(byte_idx_i) - 4) -: 8] <= byte_i;
      end
   end

   // Whole frames seen by the host.
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         frames_o <= 16'h0000;
      end else if (frame_done_i) begin
         frames_o <= frames_o + 16'h0001;
      end
   end
endmodule

// file: dsii_input_image_sva.sv
// Port checker for the drive status input image block.
module dsii_input_image_sva (
   // Clock and reset.
   input wire logic clk_i,
   input wire logic rst_i,
   // Wishbone handshake.
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_ack_o,
   // Snapshot and byte stream.
   input wire dsii_pkg::dsii_image_t image_o,
   input wire logic [7:0] byte_o,
   input wire logic [4:0] byte_idx_o,
   input wire logic byte_valid_o,
   input wire logic frame_done_o
);
   import dsii_pkg::*;
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);
   logic [7:0] exp_byte;

   // Byte owed at the present index; index 21 is the image bottom.
   assign exp_byte = 8'(image_o >> (8 * (21 - int'(byte_idx_o))));

   // Eighteen bytes, then the done pulse as the stream goes quiet.
   sequence frame_s;
      byte_idx_o == 5'h04 ##17 byte_valid_o && byte_idx_o == 5'h15
      ##1 !byte_valid_o && frame_done_o;
   endsequence

   ack_answer_a: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack missing after request");
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_idle_a: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
      else $error("ack without request");
   frame_shape_a: assert property ($rose(byte_valid_o) |-> frame_s)
      else $error("frame shape wrong");
   idx_step_a: assert property (
      byte_valid_o && $past(byte_valid_o) |->
      byte_idx_o == $past(byte_idx_o) + 5'h01)
      else $error("byte index skipped");
   byte_map_a: assert property (
      byte_valid_o |-> byte_o == exp_byte)
      else $error("byte not big-endian image byte");
   snap_hold_a: assert property (
      byte_valid_o || frame_done_o |-> $stable(image_o))
      else $error("snapshot moved in frame");
   snap_start_a: assert property (
      $changed(image_o) |=> $rose(byte_valid_o) && byte_idx_o == 5'h04)
      else $error("snapshot without frame start");
   done_pulse_a: assert property (frame_done_o |=> !frame_done_o)
      else $error("done longer than one cycle");
   alarm_mask_a: assert property (
      image_o.status[ST_ALARM] |->
      !image_o.status[ST_READY] && !image_o.status[ST_DIRECT_RDY])
      else $error("ready shown during alarm");
endmodule

// file: dsii_input_image_test.sv
// Self-checking testbench for the drive status input image block.
module dsii_input_image_test;
   timeunit 1ns;
   timeprecision 1ns;
   import dsii_pkg::*;
   logic clk_i, rst_i, cyc, stb, we, ack, req, bval, done, go;
   logic [7:0] adr, bv;
   logic [3:0] sel;
   logic [31:0] wdat, rdat, q, fpos, fspd, cpos;
   dsii_flags_t flags;
   dsii_cmds_t cmds;
   logic [NUM_SETTINGS-1:0] bad;
   logic hwa, hwb;
   logic [15:0] acode, trq, frames;
   logic [4:0] bidx;
   dsii_image_t img, rx;
   int error_cnt = 0;
   int checks_done = 0;
   int cycles = 0;

   dsii_input_image dsii_input_image_inst (
      .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
      .wb_dat_o(rdat), .wb_ack_o(ack), .flags_i(flags), .cmds_i(cmds),
      .setting_bad_i(bad), .hw_torque_off_a_i(hwa),
      .hw_torque_off_b_i(hwb), .alarm_code_i(acode), .fb_pos_i(fpos),
      .fb_speed_i(fspd), .cmd_pos_i(cpos), .torque_i(trq),
      .exch_req_i(req), .image_o(img), .byte_o(bv), .byte_idx_o(bidx),
      .byte_valid_o(bval), .frame_done_o(done));
   dsii_host_model dsii_host_model_inst (
      .clk_i(clk_i), .rst_i(rst_i), .go_i(go), .byte_i(bv),
      .byte_idx_i(bidx), .byte_valid_i(bval), .frame_done_i(done),
      .exch_req_o(req), .rx_o(rx), .frames_o(frames));

   // Free-running 100 MHz clock.
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end

   // The run needs well under a thousand cycles; a hang ends here.
   always @(posedge clk_i) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         error_cnt++;
         give_verdict();
      end
   end

   task give_verdict;
      $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   task chk(input logic [143:0] got, input logic [143:0] exp);
      checks_done++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
      end
   endtask

   // One classic cycle; ack and read data are taken at the rising edge
   // that samples ack high, and the request is released at that edge.
   task automatic wb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      wdat <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      chk(ack, 1'b1);
      q = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
   endtask

   task live(input logic [15:0] st);
      wb(1'b0, 8'h08, 32'h0000_0000);
      chk(q, {st, acode});
   endtask

   task automatic frame;
      int n;
      n = 0;
      @(posedge clk_i);
      go <= 1'b1;
      @(posedge clk_i);
      go <= 1'b0;
      do begin
         @(negedge clk_i);
         n++;
      end while (done !== 1'b1 && n < 60);
      chk(done, 1'b1);
   endtask

   function automatic dsii_image_t exp_img(input logic [15:0] st,
                                           input logic [31:0] fp, cp);
      return {st, acode, fp, fspd, cp, trq};
   endfunction

   // Every level flag except alarm and motor_excited, and every echo, at once, sent as a whole frame.
   task t_fields;
      @(posedge clk_i);
      flags <= 14'h38C5;
      cmds <= 4'hF;
      bad <= 7'h10;
      acode <= 16'h1234;
      fpos <= 32'h0004_93E0;
      fspd <= 32'h89AB_CDEF;
      cpos <= 32'hFEDC_BA98;
      trq <= 16'h03E8;
      frame();
      chk(rx, exp_img(16'hB76F, fpos, cpos));
      chk(img, exp_img(16'hB76F, fpos, cpos));
      wb(1'b0, 8'h10, 32'h0000_0000);
      chk(q, 32'hB76F_1234);
      wb(1'b0, 8'h14, 32'h0000_0000);
      chk(q, 32'h0004_93E0);
      wb(1'b0, 8'h20, 32'h0000_0000);
      chk(q, 32'h03E8_0000);
   endtask

   task t_alarm;
      @(posedge clk_i);
      flags <= 14'h00E0;
      cmds <= 4'h0;
      bad <= 7'h00;
      live(16'h0080);
      @(posedge clk_i);
      flags <= 14'h00C0;
      live(16'h0060);
   endtask

   // Either pin latches the flag until the motor is excited again.
   task automatic t_torque;
      int n;
      for (int i = 0; i < 2; i++) begin
         n = 0;
         @(posedge clk_i);
         flags <= 14'h0000;
         if (i == 0) hwa <= 1'b0;
         else hwb <= 1'b0;
         do begin
            wb(1'b0, 8'h08, 32'h0000_0000);
            n++;
         end while (q[30] !== 1'b1 && n < 10);
         @(posedge clk_i);
         hwa <= 1'b1;
         hwb <= 1'b1;
         repeat (3) live(16'h4000);
         flags <= 14'h0002;
         n = 0;
         do begin
            wb(1'b0, 8'h08, 32'h0000_0000);
            n++;
         end while (q[30] !== 1'b0 && n < 10);
         flags <= 14'h0000;
         live(16'h0000);
      end
   endtask

   // Pulsed causes; both sticky flags see set and clear in one cycle.
   task t_events;
      logic [13:0] ev [9] = '{14'h0400, 14'h0100, 14'h0200, 14'h0010,
                              14'h0008, 14'h0500, 14'h0100, 14'h0018,
                              14'h0008};
      logic [15:0] es [9] = '{16'h0010, 16'h0000, 16'h0010, 16'h0810,
                              16'h0010, 16'h0010, 16'h0000, 16'h0800,
                              16'h0000};
      for (int i = 0; i < 9; i++) begin
         @(posedge clk_i);
         flags <= ev[i];
         @(posedge clk_i);
         flags <= 14'h0000;
         live(es[i]);
      end
   endtask

   task t_wrap;
      @(posedge clk_i);
      fpos <= 32'h0000_1234;
      cpos <= 32'hFFFF_FFFF;
      wb(1'b0, 8'h04, 32'h0000_0000);
      chk(q, 32'h0000_1000);
      wb(1'b1, 8'h0C, 32'h0000_00FF);
      wb(1'b0, 8'h0C, 32'h0000_0000);
      chk(q, 32'h0000_0001);
      wb(1'b1, 8'h30, 32'hFFFF_FFFF);
      wb(1'b0, 8'h30, 32'h0000_0000);
      chk(q, 32'h0000_0000);
      wb(1'b1, 8'h00, 32'h0000_0001);
      frame();
      chk(rx, exp_img(16'h0000, 32'h0000_0234, 32'h0000_0FFF));
      // The host counts the done pulse at the next edge.
      @(negedge clk_i);
      chk(frames, 16'h0002);
   endtask

   // Auto mode re-arms after every frame with no request at all.
   task automatic t_auto;
      int n;
      wb(1'b1, 8'h00, 32'h0000_0002);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         do begin
            @(negedge clk_i);
            n++;
         end while (done !== 1'b1 && n < 60);
         chk(done, 1'b1);
      end
      @(negedge clk_i);
      chk(frames, 16'h0004);
      chk(rx, exp_img(16'h0000, fpos, cpos));
   endtask

   // Reset for two cycles, then the scenarios in order.
   initial begin
      rst_i = 1'b1;
      {cyc, stb, we, go} = 4'h0;
      adr = 8'h00;
      sel = 4'hF;
      wdat = 32'h0000_0000;
      flags = 14'h0000;
      {cmds, bad} = 11'h000;
      {hwa, hwb} = 2'h3;
      {acode, trq} = 32'h0000_0000;
      {fpos, fspd, cpos} = 96'h0;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      t_fields();
      t_alarm();
      t_torque();
      t_events();
      t_wrap();
      t_auto();
      give_verdict();
   end
endmodule

bind dsii_input_image dsii_input_image_sva dsii_input_image_sva_inst (
   .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
   .wb_ack_o(wb_ack_o), .image_o(image_o), .byte_o(byte_o),
   .byte_idx_o(byte_idx_o), .byte_valid_o(byte_valid_o),
   .frame_done_o(frame_done_o));
